// >>> common/sbse_pkg.sv
// Package: opcodes, timing counts and state types of the stack and block-search executor.
package sbse_pkg;
	localparam logic [7:0] SBSE_PFX_NONE = 8'h00;
	localparam logic [7:0] SBSE_PFX_EXT = 8'hED;
	localparam logic [7:0] SBSE_PFX_IDX2 = 8'hFD;
	localparam logic [7:0] SBSE_OPC_SEARCH_INCR_SINGLE = 8'hA1;
	localparam logic [7:0] SBSE_OPC_SEARCH_DECR_SINGLE = 8'hA9;
	localparam logic [7:0] SBSE_OPC_SEARCH_INCR_REPEAT = 8'hB1;
	localparam logic [7:0] SBSE_OPC_SEARCH_DECR_REPEAT = 8'hB9;
	localparam logic [7:0] SBSE_OPC_POP_IDX2 = 8'hE1;
	localparam logic [7:0] SBSE_OPC_PUSH_MASK = 8'hCF;
	localparam logic [7:0] SBSE_OPC_PUSH_PAIR = 8'hC5;
	localparam int SBSE_QQ_LSB = 4;
	localparam int SBSE_CLK_PERIOD_NS = 25;
	localparam int SBSE_T_STATE_NS = 25;
	localparam int SBSE_T_REPEAT = 21;
	localparam int SBSE_T_FINAL = 16;
	localparam int SBSE_T_POP_IDX2 = 14;
	localparam int SBSE_T_PUSH_PAIR = 11;
	localparam int SBSE_CYC_REPEAT = SBSE_T_REPEAT * SBSE_T_STATE_NS / SBSE_CLK_PERIOD_NS;
	localparam int SBSE_CYC_FINAL = SBSE_T_FINAL * SBSE_T_STATE_NS / SBSE_CLK_PERIOD_NS;
	localparam int SBSE_CYC_POP = SBSE_T_POP_IDX2 * SBSE_T_STATE_NS / SBSE_CLK_PERIOD_NS;
	localparam int SBSE_CYC_PUSH = SBSE_T_PUSH_PAIR * SBSE_T_STATE_NS / SBSE_CLK_PERIOD_NS;
	localparam int SBSE_TMR_W = 5;
	localparam logic [15:0] SBSE_RST_WORD = 16'h0000;
	localparam logic [7:0] SBSE_RST_BYTE = 8'h00;

	typedef enum logic [1:0] {
		SBSE_ST_IDLE = 2'b00,
		SBSE_ST_MEM = 2'b01,
		SBSE_ST_DATA = 2'b11,
		SBSE_ST_HOLD = 2'b10
	} sbse_state_e;

	typedef enum logic [2:0] {
		SBSE_OP_NONE,
		SBSE_OP_SRCH_INC,
		SBSE_OP_SRCH_DEC,
		SBSE_OP_SRCH_INC_REP,
		SBSE_OP_SRCH_DEC_REP,
		SBSE_OP_POP,
		SBSE_OP_PUSH
	} sbse_op_e;
endpackage

// >>> common/sbse_tmr_if.sv
// Interface between the executor and its T-state timer.
interface sbse_tmr_if #(parameter int W = 5);
	logic clear;
	logic enable;
	logic [W-1:0] count;
	modport ctl (output clear, output enable, input count);
	modport tmr (input clear, input enable, output count);
endinterface

// >>> design/sbse_core.sv
// Executor for stack push/pop and compare-and-search block instructions.
module sbse_core (
	input wire logic CLK_SYS_IN,
	input wire logic RST_IN,
	input wire logic CE_IN,
	input wire logic START_IN,
	input wire logic [7:0] PREFIX_IN,
	input wire logic [7:0] OPCODE_IN,
	input wire logic LOAD_IN,
	input wire logic [7:0] ACC_IN,
	input wire logic [15:0] COUNTER_IN,
	input wire logic [15:0] POINTER_IN,
	input wire logic [15:0] SP_IN,
	input wire logic [15:0] OTHER_PAIR_IN,
	input wire logic [7:0] MEM_RDATA_IN,
	output logic [15:0] MEM_ADDR_OUT,
	output logic MEM_RD_OUT,
	output logic MEM_WR_OUT,
	output logic [7:0] MEM_WDATA_OUT,
	output logic [15:0] POINTER_OUT,
	output logic [15:0] COUNTER_OUT,
	output logic [15:0] SP_OUT,
	output logic [15:0] INDEX2_OUT,
	output logic ZERO_OUT,
	output logic PV_OUT,
	output logic BUSY_OUT,
	output logic DONE_OUT,
	output logic ILLEGAL_OUT
);
	import sbse_pkg::*;

	localparam int REP_LAST = SBSE_CYC_REPEAT - 1;
	localparam int FIN_LAST = SBSE_CYC_FINAL - 1;
	sbse_state_e state, next_state;
	sbse_op_e op, dec_op, next_op;
	logic [1:0] qq, next_qq;
	logic step, next_step;
	logic [7:0] acc;
	logic [15:0] other_pair, push_val, next_addr;
	logic [SBSE_TMR_W-1:0] target_last;
	logic accept, is_search, is_rep, cont, iter_end;
	sbse_tmr_if #(.W(SBSE_TMR_W)) tif ();
	sbse_cycle_timer u_timer (
		.clk_in(CLK_SYS_IN),
		.rst_in(RST_IN),
		.tif(tif)
	);

	assign accept = CE_IN && START_IN && state == SBSE_ST_IDLE;

	// Decode of the prefix and opcode bytes at the moment the instruction is taken.
	always_comb begin
		dec_op = SBSE_OP_NONE;
		if (PREFIX_IN == SBSE_PFX_EXT) begin
			unique case (OPCODE_IN)
				SBSE_OPC_SEARCH_INCR_SINGLE: dec_op = SBSE_OP_SRCH_INC;
				SBSE_OPC_SEARCH_DECR_SINGLE: dec_op = SBSE_OP_SRCH_DEC;
				SBSE_OPC_SEARCH_INCR_REPEAT: dec_op = SBSE_OP_SRCH_INC_REP;
				SBSE_OPC_SEARCH_DECR_REPEAT: dec_op = SBSE_OP_SRCH_DEC_REP;
				default: dec_op = SBSE_OP_NONE;
			endcase
		end else if (PREFIX_IN == SBSE_PFX_IDX2 && OPCODE_IN == SBSE_OPC_POP_IDX2) begin
			dec_op = SBSE_OP_POP;
		end else if (PREFIX_IN == SBSE_PFX_NONE &&
				(OPCODE_IN & SBSE_OPC_PUSH_MASK) == SBSE_OPC_PUSH_PAIR) begin
			dec_op = SBSE_OP_PUSH;
		end
	end

	assign is_search = op inside {SBSE_OP_SRCH_INC, SBSE_OP_SRCH_DEC,
		SBSE_OP_SRCH_INC_REP, SBSE_OP_SRCH_DEC_REP};
	assign is_rep = op inside {SBSE_OP_SRCH_INC_REP, SBSE_OP_SRCH_DEC_REP};
	// Flags are settled by the time the hold phase runs, so the repeat decision is stable.
	assign cont = is_rep && !ZERO_OUT && PV_OUT;

	always_comb begin
		target_last = SBSE_TMR_W'(FIN_LAST);
		if (op == SBSE_OP_POP) begin
			target_last = SBSE_TMR_W'(SBSE_CYC_POP - 1);
		end else if (op == SBSE_OP_PUSH) begin
			target_last = SBSE_TMR_W'(SBSE_CYC_PUSH - 1);
		end else if (cont) begin
			target_last = SBSE_TMR_W'(REP_LAST);
		end
	end

	assign iter_end = state == SBSE_ST_HOLD && tif.count == target_last;

	always_comb begin
		next_state = state;
		next_step = step;
		unique case (state)
			SBSE_ST_IDLE: begin
				if (accept && dec_op != SBSE_OP_NONE) begin
					next_state = SBSE_ST_MEM;
					next_step = 1'b0;
				end
			end
			SBSE_ST_MEM: begin
				if (op == SBSE_OP_PUSH) begin
					next_state = step ? SBSE_ST_HOLD : SBSE_ST_MEM;
					next_step = 1'b1;
				end else begin
					next_state = SBSE_ST_DATA;
				end
			end
			SBSE_ST_DATA: begin
				if (op == SBSE_OP_POP && !step) begin
					next_state = SBSE_ST_MEM;
					next_step = 1'b1;
				end else begin
					next_state = SBSE_ST_HOLD;
				end
			end
			SBSE_ST_HOLD: begin
				if (iter_end) begin
					next_state = cont ? SBSE_ST_MEM : SBSE_ST_IDLE;
					next_step = 1'b0;
				end
			end
		endcase
	end

	assign next_op = (state == SBSE_ST_IDLE) ? dec_op : op;
	assign next_qq = (state == SBSE_ST_IDLE) ? OPCODE_IN[SBSE_QQ_LSB +: 2] : qq;
	assign tif.enable = CE_IN;
	assign tif.clear = next_state == SBSE_ST_MEM &&
		(state == SBSE_ST_IDLE || state == SBSE_ST_HOLD);

	always_comb begin
		unique case (next_qq)
			2'b00: push_val = COUNTER_OUT;
			2'b10: push_val = POINTER_OUT;
			default: push_val = other_pair;
		endcase
	end

	always_comb begin
		next_addr = POINTER_OUT;
		if (next_op == SBSE_OP_POP) begin
			next_addr = next_step ? SP_OUT + 16'h0001 : SP_OUT;
		end else if (next_op == SBSE_OP_PUSH) begin
			next_addr = next_step ? SP_OUT - 16'h0002 : SP_OUT - 16'h0001;
		end
	end

	always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
		if (RST_IN) begin
			state <= SBSE_ST_IDLE;
			op <= SBSE_OP_NONE;
			qq <= 2'b00;
			step <= 1'b0;
			BUSY_OUT <= 1'b0;
		end else if (CE_IN) begin
			state <= next_state;
			op <= next_op;
			qq <= next_qq;
			step <= next_step;
			BUSY_OUT <= next_state != SBSE_ST_IDLE;
		end
	end

	// Memory strobes are registered from the next state so they line up with the access phase.
	always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
		if (RST_IN) begin
			MEM_ADDR_OUT <= SBSE_RST_WORD;
			MEM_RD_OUT <= 1'b0;
			MEM_WR_OUT <= 1'b0;
			MEM_WDATA_OUT <= SBSE_RST_BYTE;
		end else if (CE_IN) begin
			MEM_ADDR_OUT <= next_addr;
			MEM_RD_OUT <= next_state == SBSE_ST_MEM && next_op != SBSE_OP_PUSH;
			MEM_WR_OUT <= next_state == SBSE_ST_MEM && next_op == SBSE_OP_PUSH;
			MEM_WDATA_OUT <= next_step ? push_val[7:0] : push_val[15:8];
		end
	end

	always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
		if (RST_IN) begin
			DONE_OUT <= 1'b0;
			ILLEGAL_OUT <= 1'b0;
		end else if (CE_IN) begin
			DONE_OUT <= iter_end && !cont;
			ILLEGAL_OUT <= accept && dec_op == SBSE_OP_NONE;
		end
	end

	// Search datapath: compare, step pointer, count down, update flags.
	always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
		if (RST_IN) begin
			acc <= SBSE_RST_BYTE;
			COUNTER_OUT <= SBSE_RST_WORD;
			POINTER_OUT <= SBSE_RST_WORD;
			ZERO_OUT <= 1'b0;
			PV_OUT <= 1'b0;
		end else if (CE_IN) begin
			if (LOAD_IN && state == SBSE_ST_IDLE) begin
				acc <= ACC_IN;
				COUNTER_OUT <= COUNTER_IN;
				POINTER_OUT <= POINTER_IN;
			end else if (state == SBSE_ST_DATA && is_search) begin
				ZERO_OUT <= acc == MEM_RDATA_IN;
				PV_OUT <= (COUNTER_OUT - 16'h0001) != 16'h0000;
				COUNTER_OUT <= COUNTER_OUT - 16'h0001;
				if (op == SBSE_OP_SRCH_DEC || op == SBSE_OP_SRCH_DEC_REP) begin
					POINTER_OUT <= POINTER_OUT - 16'h0001;
				end else begin
					POINTER_OUT <= POINTER_OUT + 16'h0001;
				end
			end
		end
	end

	// Stack datapath.
	always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
		if (RST_IN) begin
			SP_OUT <= SBSE_RST_WORD;
			INDEX2_OUT <= SBSE_RST_WORD;
			other_pair <= SBSE_RST_WORD;
		end else if (CE_IN) begin
			if (LOAD_IN && state == SBSE_ST_IDLE) begin
				SP_OUT <= SP_IN;
				other_pair <= OTHER_PAIR_IN;
			end else if (state == SBSE_ST_DATA && op == SBSE_OP_POP) begin
				if (step) begin
					INDEX2_OUT[15:8] <= MEM_RDATA_IN;
				end else begin
					INDEX2_OUT[7:0] <= MEM_RDATA_IN;
				end
			end else if (iter_end && op == SBSE_OP_POP) begin
				SP_OUT <= SP_OUT + 16'h0002;
			end else if (iter_end && op == SBSE_OP_PUSH) begin
				SP_OUT <= SP_OUT - 16'h0002;
			end
		end
	end

	default clocking cb @(posedge CLK_SYS_IN); endclocking
	default disable iff (RST_IN || !CE_IN);
	sequence s_search_step;
		state == SBSE_ST_DATA && is_search;
	endsequence
	// Iteration lengths are timed outside the timer, so a wrong terminal count cannot hide.
	sequence s_rep_next;
		##19 (state == SBSE_ST_MEM && MEM_RD_OUT);
	endsequence
	sequence s_rep_last;
		##14 (DONE_OUT && !BUSY_OUT);
	endsequence
	property p_pv_rule;
		s_search_step |=> PV_OUT == ($past(COUNTER_OUT) != 16'h0001);
	endproperty
	a_pv_rule: assert property (p_pv_rule) else $error("parity flag wrong after search");
	property p_zero_rule;
		s_search_step |=> ZERO_OUT == ($past(acc) == $past(MEM_RDATA_IN));
	endproperty
	a_zero_rule: assert property (p_zero_rule) else $error("zero flag wrong after search");
	property p_inc_rep;
		state == SBSE_ST_DATA && op == SBSE_OP_SRCH_INC_REP |=>
			(POINTER_OUT == $past(POINTER_OUT) + 16'h0001) and
			(if (cont) s_rep_next else s_rep_last);
	endproperty
	a_inc_rep: assert property (p_inc_rep) else $error("incrementing repeat timing wrong");
	property p_dec_rep;
		state == SBSE_ST_DATA && op == SBSE_OP_SRCH_DEC_REP |=>
			(POINTER_OUT == $past(POINTER_OUT) - 16'h0001) and
			(if (cont) s_rep_next else s_rep_last);
	endproperty
	a_dec_rep: assert property (p_dec_rep) else $error("decrementing repeat step wrong");
	property p_pop_time;
		accept && dec_op == SBSE_OP_POP |-> ##15 DONE_OUT;
	endproperty
	a_pop_time: assert property (p_pop_time) else $error("pop did not end after 14 T states");
	property p_pop_addr;
		MEM_RD_OUT && op == SBSE_OP_POP |-> MEM_ADDR_OUT == (step ? SP_OUT + 16'h0001 : SP_OUT);
	endproperty
	a_pop_addr: assert property (p_pop_addr) else $error("pop address wrong");
	property p_pop_decode;
		accept && PREFIX_IN == SBSE_PFX_IDX2 && OPCODE_IN == SBSE_OPC_POP_IDX2 |=>
			op == SBSE_OP_POP && state == SBSE_ST_MEM && !ILLEGAL_OUT;
	endproperty
	a_pop_decode: assert property (p_pop_decode) else $error("pop not decoded");
	property p_push_addr;
		MEM_WR_OUT |-> MEM_ADDR_OUT == (step ? SP_OUT - 16'h0002 : SP_OUT - 16'h0001);
	endproperty
	a_push_addr: assert property (p_push_addr) else $error("push address wrong");
	property p_push_sp;
		iter_end && op == SBSE_OP_PUSH |=> SP_OUT == $past(SP_OUT) - 16'h0002;
	endproperty
	a_push_sp: assert property (p_push_sp) else $error("stack pointer not lowered by two");
endmodule

// >>> design/sbse_cycle_timer.sv
// T-state timer: counts clock cycles since the start of the current iteration.
module sbse_cycle_timer (
	input wire logic clk_in,
	input wire logic rst_in,
	sbse_tmr_if.tmr tif
);
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			tif.count <= '0;
		end else if (tif.enable) begin
			if (tif.clear) begin
				tif.count <= '0;
			end else begin
				tif.count <= tif.count + 1'b1;
			end
		end
	end
endmodule

// >>> sim/sbse_mem_model.sv
// Memory model holding the stack and the searched bytes.
module sbse_mem_model (
	input wire logic clk_in,
	input wire logic [15:0] addr_in,
	input wire logic rd_in,
	input wire logic wr_in,
	input wire logic [7:0] wdata_in,
	output logic [7:0] rdata_out
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] mem [0:65535];
	logic [7:0] held = 8'h00;
	initial begin
		for (int i = 0; i < 65536; i++) begin
			mem[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h5A;
		end
	end
	// Read data stays valid through the cycle after the read, then turns to garbage so that
	// a late sample is caught instead of seeing a stale byte.
	assign rdata_out = rd_in ? mem[addr_in] : held;
	always @(posedge clk_in) begin
		if (rd_in) begin
			held <= mem[addr_in];
		end else begin
			held <= ~held;
		end
		if (wr_in) begin
			mem[addr_in] <= wdata_in;
		end
	end
endmodule

// >>> sim/stack_and_block_search_exec_tb_top.sv
// Self-checking bench for the stack and block-search executor.
module stack_and_block_search_exec_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import sbse_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1, ce = 1'b1, start = 1'b0, load = 1'b0;
	logic [7:0] pfx = 8'h00, opc = 8'h00, acc = 8'h00, rdata, wdata;
	logic [15:0] cnt = 16'h0000, ptr = 16'h0000, sp = 16'h0000, oth = 16'h0000;
	logic [15:0] addr, ptr_o, cnt_o, sp_o, idx2_o;
	logic rd, wr, zero_o, pv_o, busy, done, illegal;
	logic [99:0] exp_q[$];
	logic [99:0] pend[$];
	int fail_count = 0, checks = 0, cyc = 0;
	logic [15:0] e_idx2 = 16'h0000;
	logic e_z = 1'b0, e_pv = 1'b0;

	always #12.5 clk = ~clk;

	sbse_core dut (.CLK_SYS_IN(clk), .RST_IN(rst), .CE_IN(ce), .START_IN(start),
		.PREFIX_IN(pfx), .OPCODE_IN(opc), .LOAD_IN(load), .ACC_IN(acc), .COUNTER_IN(cnt),
		.POINTER_IN(ptr), .SP_IN(sp), .OTHER_PAIR_IN(oth), .MEM_RDATA_IN(rdata),
		.MEM_ADDR_OUT(addr), .MEM_RD_OUT(rd), .MEM_WR_OUT(wr), .MEM_WDATA_OUT(wdata),
		.POINTER_OUT(ptr_o), .COUNTER_OUT(cnt_o), .SP_OUT(sp_o), .INDEX2_OUT(idx2_o),
		.ZERO_OUT(zero_o), .PV_OUT(pv_o), .BUSY_OUT(busy), .DONE_OUT(done),
		.ILLEGAL_OUT(illegal));
	sbse_mem_model u_mem (.clk_in(clk), .addr_in(addr), .rd_in(rd), .wr_in(wr),
		.wdata_in(wdata), .rdata_out(rdata));

	task automatic check(input logic [99:0] seen, input logic [99:0] want);
		checks++;
		if (seen !== want) begin
			fail_count++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask

	task automatic complete_run();
		if (fail_count == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	function automatic logic [99:0] take_exp();
		return (exp_q.size() != 0) ? exp_q.pop_front() : 100'h0;
	endfunction

	// Every event carries the cycle it appeared in, so timing is checked with the values.
	always @(negedge clk) begin
		cyc++;
		if (done === 1'b1) begin
			check({2'd1, cyc, ptr_o, cnt_o, sp_o, idx2_o, zero_o, pv_o}, take_exp());
		end
		if (wr === 1'b1) begin
			check({2'd2, cyc, addr, 8'h00, wdata, 34'h0}, take_exp());
		end
		if (illegal === 1'b1) begin
			check({2'd3, cyc, 66'h0}, take_exp());
		end
		if (done === 1'b1 || illegal === 1'b1) begin
			check(100'(busy), 100'h0);
		end
		if (rd === 1'b1 || wr === 1'b1) begin
			check(100'(busy), 100'h1);
		end
		if (cyc > 20000) begin
			fail_count++;
			complete_run();
		end
	end

	task automatic load_regs(input logic [15:0] c, p, s, o, input logic [7:0] a);
		@(posedge clk);
		load <= 1'b1;
		cnt <= c;
		ptr <= p;
		sp <= s;
		oth <= o;
		acc <= a;
		@(posedge clk);
		load <= 1'b0;
	endtask

	// Pending notes hold offsets from the take edge; they become absolute once it is known.
	task automatic issue(input logic [7:0] p, o, input int stall);
		int n;
		logic [99:0] e;
		@(posedge clk);
		start <= 1'b1;
		pfx <= p;
		opc <= o;
		@(posedge clk);
		start <= 1'b0;
		foreach (pend[i]) begin
			e = pend[i];
			e[97:66] = e[97:66] + 32'(cyc + stall);
			exp_q.push_back(e);
		end
		pend.delete();
		if (stall > 0) begin
			ce <= 1'b0;
			repeat (stall) @(posedge clk);
			ce <= 1'b1;
		end
		n = 0;
		while (done !== 1'b1 && illegal !== 1'b1 && n < 3000) begin
			@(negedge clk);
			n++;
		end
	endtask

	task automatic search(input logic [7:0] o, input int stall);
		logic [15:0] p, c, s;
		logic [7:0] a, b;
		int k, j;
		a = 8'($urandom);
		p = 16'($urandom);
		c = 16'($urandom_range(1, 6));
		s = 16'($urandom);
		j = $urandom_range(0, int'(c) - 1);
		if ($urandom_range(0, 1) == 1) begin
			u_mem.mem[o[3] ? p - 16'(j) : p + 16'(j)] = a;
		end
		load_regs(c, p, s, 16'($urandom), a);
		k = 0;
		do begin
			b = u_mem.mem[p];
			p = o[3] ? p - 16'h0001 : p + 16'h0001;
			c = c - 16'h0001;
			e_z = (a == b);
			e_pv = (c != 16'h0000);
			k++;
		end while (o[4] && !e_z && e_pv);
		pend.push_back({2'd1, 32'(21 * k - 4), p, c, s, e_idx2, e_z, e_pv});
		issue(SBSE_PFX_EXT, o, stall);
	endtask

	task automatic stack_op(input int qq);
		logic [15:0] c, p, s, o, v;
		c = 16'($urandom);
		p = 16'($urandom);
		s = 16'($urandom);
		o = 16'($urandom);
		load_regs(c, p, s, o, 8'($urandom));
		v = (qq == 0) ? c : (qq == 2) ? p : o;
		if (qq == 4) begin
			e_idx2 = {u_mem.mem[s + 16'h0001], u_mem.mem[s]};
			pend.push_back({2'd1, 32'd15, p, c, s + 16'h0002, e_idx2, e_z, e_pv});
			issue(SBSE_PFX_IDX2, SBSE_OPC_POP_IDX2, 0);
		end else begin
			pend.push_back({2'd2, 32'd1, s - 16'h0001, 8'h00, v[15:8], 34'h0});
			pend.push_back({2'd2, 32'd2, s - 16'h0002, 8'h00, v[7:0], 34'h0});
			pend.push_back({2'd1, 32'd12, p, c, s - 16'h0002, e_idx2, e_z, e_pv});
			issue(SBSE_PFX_NONE, SBSE_OPC_PUSH_PAIR | 8'(qq << SBSE_QQ_LSB), 0);
		end
	endtask

	initial begin
		void'($urandom(97));
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			search(SBSE_OPC_SEARCH_INCR_REPEAT, 0);
			search(SBSE_OPC_SEARCH_DECR_REPEAT, 0);
			search(SBSE_OPC_SEARCH_DECR_SINGLE, 0);
			search(SBSE_OPC_SEARCH_INCR_SINGLE, i);
			for (int q = 0; q < 5; q++) begin
				stack_op(q);
			end
		end
		// A pop opcode without its prefix and a search opcode under the wrong prefix.
		pend.push_back({2'd3, 32'd1, 66'h0});
		issue(SBSE_PFX_NONE, SBSE_OPC_POP_IDX2, 0);
		pend.push_back({2'd3, 32'd1, 66'h0});
		issue(SBSE_PFX_IDX2, SBSE_OPC_SEARCH_INCR_REPEAT, 0);
		repeat (3) @(posedge clk);
		check(100'(exp_q.size()), 100'h0);
		complete_run();
	end
endmodule
